// File: rtc_temp_pkg.sv
// constants, types and register map of the rtc interrupt and temperature sequencer
// assumes an 8-bit i/o ram register port and one 10 MHz system clock
//
// Function
// - raise separate once-per-second and once-per-minute interrupt events.
// - alarm event when current minutes and hours both equal their targets.
// - seconds, minutes and alarm events all feed external interrupt six.
// - alarm fires on the cycle equality begins, not while it persists.
// - measurement logic keeps working in every power mode, processor halted too.
// - manual start in mission and brownout; periodic start in all four power modes.
// - period 0 manual, 1-6 gives 2^(3+p) seconds, 7 continuous.
// - periodic measurements are allowed in all four power modes.
// - start bit acts only with period zero, ignored in sleep and display.
// - hardware clears the start bit when its measurement finishes.
// - result upper eight bits in one byte, low three in bits 7:5.
// - result is 11-bit two's complement, range -1024 to +1023.
// - battery enable adds a battery reading to every temperature measurement.
// - power select 1 main supply, 0 clock battery; battery forced in sleep.
// - busy flag during config byte commit, up to 6 ms; writes rejected.
// - 8-bit battery result stored read-only, updated with each battery reading.
// - battery select 1 main backup battery, 0 clock battery.
package rtc_temp_pkg;

    // register byte addresses
    localparam logic [15:0] ADDR_TEMP_HIGH  = 16'h2881;
    localparam logic [15:0] ADDR_TEMP_LOW   = 16'h2882;
    localparam logic [15:0] ADDR_BATTERY    = 16'h2885;
    localparam logic [15:0] ADDR_ALARM_MIN  = 16'h289E;
    localparam logic [15:0] ADDR_ALARM_HR   = 16'h289F;
    localparam logic [15:0] ADDR_CONFIG     = 16'h28A0;
    localparam logic [15:0] ADDR_START      = 16'h28B4;

    // field positions
    localparam int CFG_PER_LSB   = 0;
    localparam int CFG_BUSY_BIT  = 3;
    localparam int CFG_BAT_BIT   = 4;
    localparam int CFG_COMP_BIT  = 5;
    localparam int CFG_PWR_BIT   = 6;
    localparam int CFG_BSEL_BIT  = 7;
    localparam int START_BIT     = 6;
    localparam int TEMP_LOW_LSB  = 5;

    // reset values
    localparam logic [7:0]  CONFIG_RST    = 8'h00;
    localparam logic [5:0]  ALARM_MIN_RST = 6'h00;
    localparam logic [4:0]  ALARM_HR_RST  = 5'h00;
    localparam logic [10:0] TEMP_RST      = 11'h000;
    localparam logic [7:0]  BATTERY_RST   = 8'h00;

    // period field codes
    localparam logic [2:0] PER_MANUAL     = 3'h0;
    localparam logic [2:0] PER_CONTINUOUS = 3'h7;
    localparam int         PER_EXP_BASE   = 3;
    localparam int         SEC_CNT_W      = 10;

    // timing
    localparam int unsigned CLK_PERIOD_NS  = 100;
    localparam int unsigned COMMIT_TIME_MS = 6;
    localparam int unsigned COMMIT_CYCLES  = (COMMIT_TIME_MS * 1000000) / CLK_PERIOD_NS;
    localparam int          COMMIT_CNT_W   = 16;

    typedef enum logic [3:0] {
        MODE_MISSION  = 4'h1,
        MODE_BROWNOUT = 4'h2,
        MODE_DISPLAY  = 4'h4,
        MODE_SLEEP    = 4'h8
    } power_mode_t;

    typedef enum logic [1:0] {
        MEAS_IDLE = 2'h1,
        MEAS_RUN  = 2'h2
    } meas_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } io_req_t;

    typedef struct packed {
        logic seconds_tick_irq;
        logic minutes_tick_irq;
        logic alarm_irq;
    } irq_events_t;

    typedef struct packed {
        logic start;
        logic power_main;
        logic battery_measure;
        logic battery_select;
    } sensor_ctl_t;

    typedef struct packed {
        logic        done;
        logic [10:0] temperature;
        logic [7:0]  battery;
    } sensor_res_t;

endpackage

// File: measure_scheduler.sv
// periodic measurement scheduler: counts rtc second ticks
// assumes sec_tick is a one-cycle pulse from the rtc on the same clock
`timescale 1ns/100ps
`default_nettype none
module measure_scheduler (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // rtc tick and period field
    input  wire logic       sec_tick,
    input  wire logic [2:0] period,
    // launch request, one cycle
    output var  logic       launch
);
    logic [rtc_temp_pkg::SEC_CNT_W-1:0] cnt_reg;
    logic [rtc_temp_pkg::SEC_CNT_W-1:0] cnt_next;
    logic [rtc_temp_pkg::SEC_CNT_W-1:0] interval;
    logic [2:0]                         period_reg;
    logic                               launch_next;
    logic                               periodic;

    assign periodic = (period != rtc_temp_pkg::PER_MANUAL)
                   && (period != rtc_temp_pkg::PER_CONTINUOUS);
    // 2^(3+p) seconds, 16 .. 512
    // shift amount kept four bits wide, a three-bit sum wraps for periods 5 and 6
    assign interval = rtc_temp_pkg::SEC_CNT_W'(1)
                   << ({1'b0, period} + 4'(rtc_temp_pkg::PER_EXP_BASE));

    always_comb begin
        cnt_next    = cnt_reg;
        launch_next = 1'b0;
        // a new period restarts the count so the first interval is whole
        if (!periodic || period != period_reg) begin
            cnt_next = '0;
        end else if (sec_tick) begin
            if (cnt_reg + 1'b1 == interval) begin
                cnt_next    = '0;
                launch_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg    <= '0;
            period_reg <= rtc_temp_pkg::PER_MANUAL;
            launch     <= 1'b0;
        end else begin
            cnt_reg    <= cnt_next;
            period_reg <= period;
            launch     <= launch_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_launch_cause;
        launch |-> $past(sec_tick) && $past(periodic) && cnt_reg == '0;
    endproperty
    a_launch_cause: assert property (p_launch_cause) else $error("launch without tick");

    property p_count_bound;
        periodic && period == period_reg |-> cnt_reg < interval;
    endproperty
    a_count_bound: assert property (p_count_bound) else $error("count past interval");
endmodule
`default_nettype wire

// File: rtc_temp_sequencer.sv
// rtc interrupt events, alarm compare and temperature measurement sequencer
// assumes processor i/o ram strobes, rtc ticks, counters and sensor on the same clock
`timescale 1ns/100ps
`default_nettype none
module rtc_temp_sequencer #(
    parameter int unsigned COMMIT_CYCLES = rtc_temp_pkg::COMMIT_CYCLES
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    // processor i/o ram port
    input  wire rtc_temp_pkg::io_req_t     io_req,
    output var  logic [7:0]                io_rdata,
    // rtc time base
    input  wire logic                      sec_tick,
    input  wire logic                      min_tick,
    input  wire logic [5:0]                current_minutes,
    input  wire logic [4:0]                current_hours,
    // power mode from the power controller
    input  wire rtc_temp_pkg::power_mode_t power_mode,
    // interrupt events towards external interrupt six
    output var  rtc_temp_pkg::irq_events_t irq_events,
    output var  logic                      ext_int6,
    // temperature sensor
    output var  rtc_temp_pkg::sensor_ctl_t sensor_ctl,
    input  wire rtc_temp_pkg::sensor_res_t sensor_res
);
    function automatic logic hit(input rtc_temp_pkg::io_req_t r, input logic [15:0] a);
        hit = r.addr == a;
    endfunction

    // register group
    logic [7:0]                           config_reg;
    logic [7:0]                           config_next;
    logic [5:0]                           alarm_min_reg;
    logic [5:0]                           alarm_min_next;
    logic [4:0]                           alarm_hr_reg;
    logic [4:0]                           alarm_hr_next;
    logic                                 start_reg;
    logic                                 start_next;
    logic [rtc_temp_pkg::COMMIT_CNT_W-1:0] commit_reg;
    logic [rtc_temp_pkg::COMMIT_CNT_W-1:0] commit_next;
    logic [7:0]                           rdata_next;
    logic                                 busy;
    logic                                 start_accept;
    logic                                 low_power;
    logic [2:0]                           period;
    // interrupt group
    logic                                 match_reg;
    logic                                 match_now;
    rtc_temp_pkg::irq_events_t            irq_next;
    // measurement group
    rtc_temp_pkg::meas_state_t            state_reg;
    rtc_temp_pkg::meas_state_t            state_next;
    logic [10:0]                          temp_reg;
    logic [10:0]                          temp_next;
    logic [7:0]                           battery_reg;
    logic [7:0]                           battery_next;
    logic                                 bat_meas_reg;
    logic                                 bat_meas_next;
    rtc_temp_pkg::sensor_ctl_t            ctl_next;
    logic                                 sched_launch;
    logic                                 launch;
    logic                                 meas_done;

    assign busy      = commit_reg != '0;
    assign period    = config_reg[rtc_temp_pkg::CFG_PER_LSB +: 3];
    assign low_power = (power_mode == rtc_temp_pkg::MODE_SLEEP)
                    || (power_mode == rtc_temp_pkg::MODE_DISPLAY);
    assign meas_done = (state_reg == rtc_temp_pkg::MEAS_RUN) && sensor_res.done;
    // manual start needs period zero and an awake processor mode
    assign start_accept = io_req.wr && hit(io_req, rtc_temp_pkg::ADDR_START)
                       && io_req.wdata[rtc_temp_pkg::START_BIT] && !start_reg
                       && period == rtc_temp_pkg::PER_MANUAL && !low_power;

    measure_scheduler u_sched (
        .clk      (clk),
        .rst      (rst),
        .sec_tick (sec_tick),
        .period   (period),
        .launch   (sched_launch)
    );

    // registers and read port
    always_comb begin
        config_next    = config_reg;
        alarm_min_next = alarm_min_reg;
        alarm_hr_next  = alarm_hr_reg;
        start_next     = start_reg;
        commit_next    = busy ? commit_reg - 1'b1 : commit_reg;
        rdata_next     = io_rdata;
        if (io_req.wr) begin
            // a write during the commit is dropped so the byte stays coherent
            if (hit(io_req, rtc_temp_pkg::ADDR_CONFIG) && !busy) begin
                config_next = io_req.wdata;
                config_next[rtc_temp_pkg::CFG_BUSY_BIT] = 1'b0;
                commit_next = rtc_temp_pkg::COMMIT_CNT_W'(COMMIT_CYCLES);
            end
            if (hit(io_req, rtc_temp_pkg::ADDR_ALARM_MIN)) begin
                alarm_min_next = io_req.wdata[5:0];
            end
            if (hit(io_req, rtc_temp_pkg::ADDR_ALARM_HR)) begin
                alarm_hr_next = io_req.wdata[4:0];
            end
        end
        // setting is only accepted while clear; if a clear falls in the same cycle, the setting wins
        if (start_accept) begin
            start_next = 1'b1;
        end else if (meas_done) begin
            start_next = 1'b0;
        end
        if (io_req.rd) begin
            unique case (io_req.addr)
                rtc_temp_pkg::ADDR_TEMP_HIGH: rdata_next = temp_reg[10:3];
                rtc_temp_pkg::ADDR_TEMP_LOW:  rdata_next = {temp_reg[2:0], 5'h00};
                rtc_temp_pkg::ADDR_BATTERY:   rdata_next = battery_reg;
                rtc_temp_pkg::ADDR_ALARM_MIN: rdata_next = {2'h0, alarm_min_reg};
                rtc_temp_pkg::ADDR_ALARM_HR:  rdata_next = {3'h0, alarm_hr_reg};
                rtc_temp_pkg::ADDR_CONFIG: begin
                    rdata_next = config_reg;
                    rdata_next[rtc_temp_pkg::CFG_BUSY_BIT] = busy;
                end
                rtc_temp_pkg::ADDR_START:     rdata_next = {1'h0, start_reg, 6'h00};
                default:                      rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            config_reg    <= rtc_temp_pkg::CONFIG_RST;
            alarm_min_reg <= rtc_temp_pkg::ALARM_MIN_RST;
            alarm_hr_reg  <= rtc_temp_pkg::ALARM_HR_RST;
            start_reg     <= 1'b0;
            commit_reg    <= '0;
            io_rdata      <= 8'h00;
        end else begin
            config_reg    <= config_next;
            alarm_min_reg <= alarm_min_next;
            alarm_hr_reg  <= alarm_hr_next;
            start_reg     <= start_next;
            commit_reg    <= commit_next;
            io_rdata      <= rdata_next;
        end
    end

    // interrupt events
    assign match_now = (current_minutes == alarm_min_reg)
                    && (current_hours == alarm_hr_reg);

    always_comb begin
        irq_next.seconds_tick_irq = sec_tick;
        irq_next.minutes_tick_irq = min_tick;
        irq_next.alarm_irq        = match_now && !match_reg;
    end

    // match starts set so a reset at a matching time gives no false alarm
    always_ff @(posedge clk) begin
        if (rst) begin
            match_reg  <= 1'b1;
            irq_events <= '0;
            ext_int6   <= 1'b0;
        end else begin
            match_reg  <= match_now;
            irq_events <= irq_next;
            ext_int6   <= |irq_next;
        end
    end

    // measurement sequencer, runs in every power mode
    assign launch = (state_reg == rtc_temp_pkg::MEAS_IDLE)
                 && (start_accept || sched_launch
                     || period == rtc_temp_pkg::PER_CONTINUOUS);

    always_comb begin
        state_next    = state_reg;
        temp_next     = temp_reg;
        battery_next  = battery_reg;
        bat_meas_next = bat_meas_reg;
        ctl_next.start = 1'b0;
        // clock battery is forced in the low power modes
        ctl_next.power_main = config_reg[rtc_temp_pkg::CFG_PWR_BIT] && !low_power;
        ctl_next.battery_select = config_reg[rtc_temp_pkg::CFG_BSEL_BIT];
        ctl_next.battery_measure = bat_meas_reg;
        unique case (state_reg)
            rtc_temp_pkg::MEAS_IDLE: begin
                if (launch) begin
                    state_next     = rtc_temp_pkg::MEAS_RUN;
                    ctl_next.start = 1'b1;
                    bat_meas_next  = config_reg[rtc_temp_pkg::CFG_BAT_BIT];
                    ctl_next.battery_measure = bat_meas_next;
                end
            end
            rtc_temp_pkg::MEAS_RUN: begin
                if (sensor_res.done) begin
                    state_next = rtc_temp_pkg::MEAS_IDLE;
                    temp_next  = sensor_res.temperature;
                    if (bat_meas_reg) begin
                        battery_next = sensor_res.battery;
                    end
                    bat_meas_next = 1'b0;
                    ctl_next.battery_measure = 1'b0;
                end
            end
            default: state_next = rtc_temp_pkg::MEAS_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg    <= rtc_temp_pkg::MEAS_IDLE;
            temp_reg     <= rtc_temp_pkg::TEMP_RST;
            battery_reg  <= rtc_temp_pkg::BATTERY_RST;
            bat_meas_reg <= 1'b0;
            sensor_ctl   <= '0;
        end else begin
            state_reg    <= state_next;
            temp_reg     <= temp_next;
            battery_reg  <= battery_next;
            bat_meas_reg <= bat_meas_next;
            sensor_ctl   <= ctl_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_sec_event;
        sec_tick |=> irq_events.seconds_tick_irq && ext_int6;
    endproperty
    a_sec_event: assert property (p_sec_event) else $error("second tick lost");

    property p_alarm_cause;
        irq_events.alarm_irq |-> $past(current_minutes) == $past(alarm_min_reg)
                              && $past(current_hours) == $past(alarm_hr_reg);
    endproperty
    a_alarm_cause: assert property (p_alarm_cause) else $error("alarm without match");

    property p_int6_merge;
        ext_int6 == (irq_events.seconds_tick_irq || irq_events.minutes_tick_irq
                     || irq_events.alarm_irq);
    endproperty
    a_int6_merge: assert property (p_int6_merge) else $error("int6 not merged");

    property p_alarm_once;
        irq_events.alarm_irq |=> !irq_events.alarm_irq;
    endproperty
    a_alarm_once: assert property (p_alarm_once) else $error("alarm repeated");

    property p_start_ignored;
        io_req.wr && hit(io_req, rtc_temp_pkg::ADDR_START) && low_power && !start_reg
            |=> !start_reg;
    endproperty
    a_start_ignored: assert property (p_start_ignored) else $error("start taken in low power");

    property p_start_clears;
        start_reg && meas_done |=> !start_reg;
    endproperty
    a_start_clears: assert property (p_start_clears) else $error("start not cleared");

    property p_busy_lock;
        io_req.wr && hit(io_req, rtc_temp_pkg::ADDR_CONFIG) && busy |=> $stable(config_reg);
    endproperty
    a_busy_lock: assert property (p_busy_lock) else $error("write during commit");

    property p_low_power_battery;
        low_power |=> !sensor_ctl.power_main;
    endproperty
    a_low_power_battery: assert property (p_low_power_battery) else $error("main supply in sleep");

    property p_low_byte;
        io_req.rd && hit(io_req, rtc_temp_pkg::ADDR_TEMP_LOW)
            |=> io_rdata[4:0] == 5'h00 && io_rdata[7:5] == 3'($past(temp_reg));
    endproperty
    a_low_byte: assert property (p_low_byte) else $error("low result byte wrong");

    property p_battery_store;
        meas_done && bat_meas_reg |=> battery_reg == $past(sensor_res.battery);
    endproperty
    a_battery_store: assert property (p_battery_store) else $error("battery not stored");

    property p_continuous;
        state_reg == rtc_temp_pkg::MEAS_IDLE && period == rtc_temp_pkg::PER_CONTINUOUS
            |=> sensor_ctl.start;
    endproperty
    a_continuous: assert property (p_continuous) else $error("continuous mode stalled");

    property p_cov_alarm;
        irq_events.alarm_irq;
    endproperty
    c_alarm: cover property (p_cov_alarm);

    property p_cov_manual;
        start_accept ##[1:50] start_reg && meas_done;
    endproperty
    c_manual: cover property (p_cov_manual);

    property p_cov_periodic;
        sched_launch && low_power;
    endproperty
    c_periodic: cover property (p_cov_periodic);
endmodule
`default_nettype wire

// File: sensor_model.sv
// behavioural temperature sensor that answers start pulses from the sequencer
// assumes start is a one-cycle pulse on clk; the bench sets delay and readings
`timescale 1ns/100ps
`default_nettype none
module sensor_model (
    // clock
    input  wire logic                      clk,
    // sequencer side
    input  wire rtc_temp_pkg::sensor_ctl_t ctl,
    output var  rtc_temp_pkg::sensor_res_t res,
    // scenario control
    input  wire logic [7:0]                delay,
    input  wire logic [10:0]               temp_val,
    input  wire logic [7:0]                bat_val,
    output var  int                        n_starts
);
    initial begin
        res = '0;
        n_starts = 0;
        forever begin
            @(posedge clk);
            if (ctl.start === 1'b1) begin
                n_starts++;
                repeat (delay) @(negedge clk);
                // 11-bit two's complement reading, valid only with done
                res = {1'b1, temp_val, bat_val};
                @(negedge clk);
                // outside done the result lines carry no reading, so show the inverse
                res = {1'b0, ~temp_val, ~bat_val};
            end
        end
    end
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the rtc interrupt and temperature sequencer
// assumes the sensor model on the far side; inputs change at the falling edge
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic                      clk = 1'b0;
    logic                      rst = 1'b1;
    rtc_temp_pkg::io_req_t     io_req = '0;
    logic [7:0]                io_rdata;
    logic                      sec_tick = 1'b0;
    logic                      min_tick = 1'b0;
    logic [5:0]                cur_min = 6'h07;
    logic [4:0]                cur_hr = 5'h00;
    rtc_temp_pkg::power_mode_t power_mode = rtc_temp_pkg::MODE_MISSION;
    rtc_temp_pkg::irq_events_t irq_events;
    logic                      ext_int6;
    rtc_temp_pkg::sensor_ctl_t sensor_ctl;
    rtc_temp_pkg::sensor_res_t sensor_res;
    int                        n_starts;
    int                        base;
    int                        bad_count = 0;
    int                        n_compared = 0;
    logic [7:0]                d;

    always #50 clk = ~clk;

    rtc_temp_sequencer #(.COMMIT_CYCLES(20)) i_rtc_temp_sequencer (
        .clk(clk), .rst(rst), .io_req(io_req), .io_rdata(io_rdata), .sec_tick(sec_tick),
        .min_tick(min_tick), .current_minutes(cur_min), .current_hours(cur_hr),
        .power_mode(power_mode), .irq_events(irq_events), .ext_int6(ext_int6),
        .sensor_ctl(sensor_ctl), .sensor_res(sensor_res));

    sensor_model i_sensor_model (
        .clk(clk), .ctl(sensor_ctl), .res(sensor_res), .delay(8'h06),
        .temp_val(11'h7FD), .bat_val(8'h85), .n_starts(n_starts));

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic cmp(logic [7:0] got, logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(logic [15:0] a, logic [7:0] v);
        io_req.wr = 1'b1;
        io_req.addr = a;
        io_req.wdata = v;
        @(negedge clk);
        io_req.wr = 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(logic [15:0] a, output logic [7:0] v);
        io_req.rd = 1'b1;
        io_req.addr = a;
        @(negedge clk);
        io_req.rd = 1'b0;
        v = io_rdata;
        @(negedge clk);
    endtask

    task automatic chk_reg(logic [15:0] a, logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        cmp(v, exp);
    endtask

    // one cycle of rtc stimulus, then the event outputs of the following cycle
    task automatic chk_evt(logic s, logic m, logic [5:0] mi, logic [4:0] hr, logic [3:0] exp);
        sec_tick = s;
        min_tick = m;
        cur_min = mi;
        cur_hr = hr;
        @(negedge clk);
        sec_tick = 1'b0;
        min_tick = 1'b0;
        cmp({4'h0, irq_events, ext_int6}, {4'h0, exp});
        @(negedge clk);
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        summarize();
    end

    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        chk_reg(rtc_temp_pkg::ADDR_ALARM_MIN, 8'h00);
        chk_reg(rtc_temp_pkg::ADDR_ALARM_HR, 8'h00);
        chk_reg(rtc_temp_pkg::ADDR_CONFIG, 8'h00);
        chk_reg(16'h2800, 8'h00);
        $display("test reset values done");
        wr(rtc_temp_pkg::ADDR_ALARM_MIN, 8'h05);
        wr(rtc_temp_pkg::ADDR_ALARM_HR, 8'h03);
        chk_evt(1'b1, 1'b0, 6'h07, 5'h03, 4'b1001);
        chk_evt(1'b0, 1'b1, 6'h07, 5'h03, 4'b0101);
        chk_evt(1'b0, 1'b0, 6'h05, 5'h03, 4'b0011);
        chk_evt(1'b0, 1'b0, 6'h05, 5'h03, 4'b0000);
        chk_evt(1'b1, 1'b1, 6'h05, 5'h02, 4'b1101);
        $display("test interrupts done");
        wr(rtc_temp_pkg::ADDR_CONFIG, 8'h10);
        chk_reg(rtc_temp_pkg::ADDR_CONFIG, 8'h18);
        wr(rtc_temp_pkg::ADDR_CONFIG, 8'h00);
        chk_reg(rtc_temp_pkg::ADDR_CONFIG, 8'h18);
        repeat (22) @(negedge clk);
        chk_reg(rtc_temp_pkg::ADDR_CONFIG, 8'h10);
        $display("test config lockout done");
        wr(rtc_temp_pkg::ADDR_START, 8'h40);
        cmp({7'h00, sensor_ctl.battery_measure}, 8'h01);
        rd(rtc_temp_pkg::ADDR_START, d);
        cmp(d, 8'h40);
        for (int i = 0; i < 40 && d[6] === 1'b1; i++) rd(rtc_temp_pkg::ADDR_START, d);
        cmp(d, 8'h00);
        cmp({7'h00, sensor_ctl.battery_measure}, 8'h00);
        chk_reg(rtc_temp_pkg::ADDR_TEMP_HIGH, 8'hFF);
        chk_reg(rtc_temp_pkg::ADDR_TEMP_LOW, 8'hA0);
        chk_reg(rtc_temp_pkg::ADDR_BATTERY, 8'h85);
        $display("test manual measurement done");
        wr(rtc_temp_pkg::ADDR_CONFIG, 8'hD0);
        @(negedge clk);
        cmp({6'h00, sensor_ctl.power_main, sensor_ctl.battery_select}, 8'h03);
        power_mode = rtc_temp_pkg::MODE_SLEEP;
        @(negedge clk);
        cmp({7'h00, sensor_ctl.power_main}, 8'h00);
        base = n_starts;
        wr(rtc_temp_pkg::ADDR_START, 8'h40);
        repeat (12) @(negedge clk);
        cmp(8'(n_starts - base), 8'h00);
        $display("test sleep mode done");
        power_mode = rtc_temp_pkg::MODE_DISPLAY;
        repeat (22) @(negedge clk);
        wr(rtc_temp_pkg::ADDR_CONFIG, 8'h01);
        for (int i = 0; i < 15; i++) chk_evt(1'b1, 1'b0, 6'h05, 5'h02, 4'b1001);
        repeat (3) @(negedge clk);
        cmp(8'(n_starts - base), 8'h00);
        chk_evt(1'b1, 1'b0, 6'h05, 5'h02, 4'b1001);
        repeat (3) @(negedge clk);
        cmp(8'(n_starts - base), 8'h01);
        $display("test periodic done");
        repeat (22) @(negedge clk);
        power_mode = rtc_temp_pkg::MODE_BROWNOUT;
        base = n_starts;
        wr(rtc_temp_pkg::ADDR_CONFIG, 8'h07);
        repeat (40) @(negedge clk);
        cmp({7'h00, (n_starts - base) > 2}, 8'h01);
        $display("test continuous done");
        summarize();
    end
endmodule
`default_nettype wire
